/* xsx_exec.sv */
// execution of the extended stack instructions and indexed operand mapping
//
// Summary of operation
// - move_indexed_to_indexed is two words: 1110 1011 1 + zs, then 1111 xxxxx + zd.
// - both move addresses are stack_frame_pointer plus 7-bit offset, anywhere in 4 KB.
// - move copies source byte to destination, no status flags touched.
// - move source on an indirect addressing register yields 00h.
// - move destination on an indirect addressing register: no write, acts as no-op.
// - push_literal_decrement writes literal at stack_frame_pointer then decrements it.
// - subtract_from_pointer subtracts 6-bit literal from pointer 0, 1 or 2.
// - select 11 subtracts from stack_frame_pointer then returns from return_stack_top.
// - subtract_and_return takes two cycles, second one a no-op.
// - extension enable also turns on indexed literal offset addressing.
// - extension off: access bit 0 is access bank, 1 is bank_select_register bank.
// - extension on, access bit 0, operand 5Fh or less: offset from stack_frame_pointer.
// - stack_frame_pointer of 00h reproduces the legacy access mapping.
// - bracketed indexed operand takes access bit as 0.
// - destination select bit keeps its meaning in indexed mode.
// - extension_enable_bit defaults to 0, everything extended disabled.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module xsx_exec
#(
	parameter int unsigned ADDR_W = xsx_pkg::ADDR_W,
	parameter int unsigned DATA_W = xsx_pkg::DATA_W
)
(
	input  wire logic              CLK_I,
	input  wire logic              RST_I,
	input  wire logic              EXT_ENABLE_I,
	input  wire logic              INSTR_VALID_I,
	input  wire logic [15:0]       INSTR_I,
	input  wire logic [3:0]        BANK_SELECT_I,
	input  wire logic [DATA_W-1:0] MEM_RDATA_I,
	input  wire logic [20:0]       RETURN_STACK_TOP_I,
	output logic                   MEM_RD_O,
	output logic                   MEM_WR_O,
	output logic [ADDR_W-1:0]      MEM_ADDR_O,
	output logic [DATA_W-1:0]      MEM_WDATA_O,
	output logic [ADDR_W-1:0]      OPERAND_ADDR_O,
	output logic                   OPERAND_TO_FILE_O,
	output logic                   PC_LOAD_O,
	output logic [20:0]            PC_VALUE_O,
	output logic                   BUSY_O,
	output logic                   EXT_ACTIVE_O,
	output logic [ADDR_W-1:0]      STACK_FRAME_POINTER_O
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_indirect(input logic [ADDR_W-1:0] a);
		is_indirect = (a >= xsx_pkg::INDF2_ADDR
			&& a <= xsx_pkg::INDF2_ADDR + xsx_pkg::IND_PORT_SPAN)
			|| (a >= xsx_pkg::INDF1_ADDR
			&& a <= xsx_pkg::INDF1_ADDR + xsx_pkg::IND_PORT_SPAN)
			|| (a >= xsx_pkg::INDF0_ADDR
			&& a <= xsx_pkg::INDF0_ADDR + xsx_pkg::IND_PORT_SPAN);
	endfunction

	// pointer plus unsigned offset, wrapped
	function automatic logic [ADDR_W-1:0] ptr_add(input logic [ADDR_W-1:0] p,
		input logic [7:0] k);
		ptr_add = ADDR_W'(p + {4'h0, k});
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	xsx_pkg::xsx_state_e state_q, state_d;
	xsx_pkg::xsx_mem_req_s req_q, req_d;
	logic [DATA_W-1:0] move_data_q, move_data_d;
	logic              src_indirect_q, src_indirect_d;
	logic [ADDR_W-1:0] oper_q, oper_d;
	logic              to_file_q, to_file_d;
	logic              pc_load_q, pc_load_d;
	logic [20:0]       pc_val_q, pc_val_d;
	logic              ext_q;

	logic              pwr;
	logic [1:0]        psel;
	logic [ADDR_W-1:0] pdata;
	logic [ADDR_W-1:0] ptr0, ptr1, ptr2, sel_ptr;

	xsx_ptr_file #(.ADDR_W(ADDR_W)) u_ptrs
	(
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.wr_i    (pwr),
		.wsel_i  (psel),
		.wdata_i (pdata),
		.ptr0_o  (ptr0),
		.ptr1_o  (ptr1),
		.ptr2_o  (ptr2)
	);

	always_comb
	begin
		case (INSTR_I[7:6])
			2'h0:    sel_ptr = ptr0;
			2'h1:    sel_ptr = ptr1;
			default: sel_ptr = ptr2;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// decode and execute

	always_comb
	begin
		state_d        = state_q;
		req_d          = '0;
		move_data_d    = move_data_q;
		src_indirect_d = src_indirect_q;
		oper_d         = oper_q;
		to_file_d      = to_file_q;
		pc_load_d      = 1'b0;
		pc_val_d       = pc_val_q;
		pwr            = 1'b0;
		psel           = 2'h2;
		pdata          = ptr2;
		case (state_q)
			xsx_pkg::XSX_IDLE:
			begin
				if (INSTR_VALID_I && ext_q)
				begin
					if (INSTR_I[15:7] == xsx_pkg::OP_MOVE_IDX_W1)
					begin
						// first word: read source
						req_d.rd = 1'b1;
						req_d.addr = ptr_add(ptr2, {1'b0, INSTR_I[6:0]});
						src_indirect_d = is_indirect(req_d.addr);
						state_d = xsx_pkg::XSX_MOVE2;
					end
					else if (INSTR_I[15:8] == xsx_pkg::OP_PUSH_LIT)
					begin
						req_d.wr = 1'b1;
						req_d.addr = ptr2;
						req_d.wdata = INSTR_I[7:0];
						pwr = 1'b1;
						pdata = ADDR_W'(ptr2 - 12'h001);
					end
					else if (INSTR_I[15:8] == xsx_pkg::OP_SUB_PTR)
					begin
						pwr = 1'b1;
						psel = (INSTR_I[7:6] == xsx_pkg::SEL_RETURN) ? 2'h2 : INSTR_I[7:6];
						pdata = ADDR_W'(sel_ptr - {6'h00, INSTR_I[5:0]});
						if (INSTR_I[7:6] == xsx_pkg::SEL_RETURN)
						begin
							pc_load_d = 1'b1;
							pc_val_d = RETURN_STACK_TOP_I;
							state_d = xsx_pkg::XSX_RETNOP;
						end
					end
				end
				// operand mapping for standard byte and bit instructions
				if (INSTR_VALID_I)
				begin
					to_file_d = INSTR_I[9];
					if (ext_q && !INSTR_I[8] && INSTR_I[7:0] <= xsx_pkg::IDX_OFFSET_MAX)
						oper_d = ptr_add(ptr2, INSTR_I[7:0]);
					else if (!INSTR_I[8])
						oper_d = (INSTR_I[7:0] <= xsx_pkg::IDX_OFFSET_MAX)
							? {4'h0, INSTR_I[7:0]}
							: xsx_pkg::ACCESS_HIGH_BASE | {4'h0, INSTR_I[7:0]};
					else
						oper_d = {BANK_SELECT_I, INSTR_I[7:0]};
				end
			end
			xsx_pkg::XSX_MOVE2:
			begin
				// source byte stands only in the cycle after the read
				if (req_q.rd)
					move_data_d = MEM_RDATA_I;
				if (INSTR_VALID_I && INSTR_I[15:12] == xsx_pkg::OP_SECOND_WORD)
				begin
					// second word: write destination unless indirect
					req_d.addr = ptr_add(ptr2, {1'b0, INSTR_I[6:0]});
					req_d.wr = !is_indirect(req_d.addr);
					req_d.wdata = src_indirect_q ? xsx_pkg::INDIRECT_READ_VALUE
						: (req_q.rd ? MEM_RDATA_I : move_data_q);
					state_d = xsx_pkg::XSX_IDLE;
				end
			end
			xsx_pkg::XSX_RETNOP:
				state_d = xsx_pkg::XSX_IDLE;
			default:
				state_d = xsx_pkg::XSX_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state_q        <= xsx_pkg::XSX_IDLE;
			req_q          <= '0;
			move_data_q    <= '0;
			src_indirect_q <= 1'b0;
			oper_q         <= '0;
			to_file_q      <= 1'b0;
			pc_load_q      <= 1'b0;
			pc_val_q       <= '0;
			ext_q          <= xsx_pkg::EXT_ENABLE_RESET;
		end
		else
		begin
			state_q        <= state_d;
			req_q          <= req_d;
			move_data_q    <= move_data_d;
			src_indirect_q <= src_indirect_d;
			oper_q         <= oper_d;
			to_file_q      <= to_file_d;
			pc_load_q      <= pc_load_d;
			pc_val_q       <= pc_val_d;
			ext_q          <= EXT_ENABLE_I;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	logic [ADDR_W-1:0] sfp_q, sfp_d;
	logic              busy_q, busy_d;

	always_comb
	begin
		sfp_d  = (pwr && psel == 2'h2) ? pdata : ptr2;
		busy_d = (state_d != xsx_pkg::XSX_IDLE);
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			sfp_q  <= xsx_pkg::PTR_RESET;
			busy_q <= 1'b0;
		end
		else
		begin
			sfp_q  <= sfp_d;
			busy_q <= busy_d;
		end
	end

	assign MEM_RD_O              = req_q.rd;
	assign MEM_WR_O              = req_q.wr;
	assign MEM_ADDR_O            = req_q.addr;
	assign MEM_WDATA_O           = req_q.wdata;
	assign OPERAND_ADDR_O        = oper_q;
	assign OPERAND_TO_FILE_O     = to_file_q;
	assign PC_LOAD_O             = pc_load_q;
	assign PC_VALUE_O            = pc_val_q;
	assign BUSY_O                = busy_q;
	assign EXT_ACTIVE_O          = ext_q;
	assign STACK_FRAME_POINTER_O = sfp_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	push_addr_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_IDLE && ext_q && INSTR_VALID_I
		&& INSTR_I[15:8] == xsx_pkg::OP_PUSH_LIT)
		|=> (MEM_WR_O && MEM_ADDR_O == $past(ptr2)
		&& STACK_FRAME_POINTER_O == 12'($past(ptr2) - 12'h001)))
		else $error("push literal wrong address or pointer");

	sub_ptr_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_IDLE && ext_q && INSTR_VALID_I
		&& INSTR_I[15:6] == {xsx_pkg::OP_SUB_PTR, 2'h2})
		|=> (STACK_FRAME_POINTER_O == 12'($past(ptr2) - {6'h00, $past(INSTR_I[5:0])})))
		else $error("subtract from pointer wrong");

	ret_load_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_IDLE && ext_q && INSTR_VALID_I
		&& INSTR_I[15:6] == {xsx_pkg::OP_SUB_PTR, xsx_pkg::SEL_RETURN})
		|=> (PC_LOAD_O && PC_VALUE_O == $past(RETURN_STACK_TOP_I) && BUSY_O)
		##1 !BUSY_O)
		else $error("subtract and return sequence wrong");

	move_read_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_IDLE && ext_q && INSTR_VALID_I
		&& INSTR_I[15:7] == xsx_pkg::OP_MOVE_IDX_W1)
		|=> (MEM_RD_O && !MEM_WR_O
		&& MEM_ADDR_O == 12'($past(ptr2) + {5'h00, $past(INSTR_I[6:0])})))
		else $error("move source read wrong");

	move_nowrite_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_MOVE2 && INSTR_VALID_I
		&& INSTR_I[15:12] == xsx_pkg::OP_SECOND_WORD
		&& is_indirect(12'(ptr2 + {5'h00, INSTR_I[6:0]})))
		|=> !MEM_WR_O)
		else $error("write to indirect register during move");

	move_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_MOVE2 && src_indirect_q && INSTR_VALID_I
		&& INSTR_I[15:12] == xsx_pkg::OP_SECOND_WORD)
		|=> MEM_WDATA_O == xsx_pkg::INDIRECT_READ_VALUE)
		else $error("indirect source not zero");

	idx_oper_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_IDLE && ext_q && INSTR_VALID_I && !INSTR_I[8]
		&& INSTR_I[7:0] <= xsx_pkg::IDX_OFFSET_MAX)
		|=> OPERAND_ADDR_O == 12'($past(ptr2) + {4'h0, $past(INSTR_I[7:0])}))
		else $error("indexed operand address wrong");

	bank_oper_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_IDLE && INSTR_VALID_I && INSTR_I[8])
		|=> OPERAND_ADDR_O == {$past(BANK_SELECT_I), $past(INSTR_I[7:0])})
		else $error("banked operand address wrong");

	sub_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		(state_q == xsx_pkg::XSX_IDLE && ext_q && INSTR_VALID_I
		&& INSTR_I[15:6] == {xsx_pkg::OP_SUB_PTR, 2'h1})
		|=> (STACK_FRAME_POINTER_O == $past(ptr2) && !PC_LOAD_O
		&& ptr1 == 12'($past(ptr1) - {6'h00, $past(INSTR_I[5:0])})))
		else $error("subtract from pointer one wrong");

endmodule // xsx_exec

/* xsx_pkg.sv */
// shared constants and types for the extended stack instruction block
package xsx_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;

	// opcode patterns, upper bits of the instruction word
	localparam logic [8:0]  OP_MOVE_IDX_W1 = 9'h1D7;   // 1110 1011 1
	localparam logic [3:0]  OP_SECOND_WORD = 4'hF;     // 1111
	localparam logic [7:0]  OP_PUSH_LIT    = 8'hFA;    // 1111 1010
	localparam logic [7:0]  OP_SUB_PTR     = 8'hE9;    // 1110 1001
	localparam logic [1:0]  SEL_RETURN     = 2'h3;     // pointer select 11

	// indexed literal offset window
	localparam logic [7:0]  IDX_OFFSET_MAX = 8'h5F;
	localparam logic [ADDR_W-1:0] ACCESS_HIGH_BASE = 12'hF00;

	// indirect addressing register locations (three pointers, five ports each)
	localparam logic [ADDR_W-1:0] INDF0_ADDR = 12'hFEF;
	localparam logic [ADDR_W-1:0] INDF1_ADDR = 12'hFE7;
	localparam logic [ADDR_W-1:0] INDF2_ADDR = 12'hFDF;
	localparam logic [ADDR_W-1:0] IND_PORT_SPAN = 12'h004;

	localparam logic [DATA_W-1:0] INDIRECT_READ_VALUE = 8'h00;
	localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
	localparam logic EXT_ENABLE_RESET = 1'b0;

	typedef enum logic [1:0]
	{
		XSX_IDLE   = 2'b00,
		XSX_MOVE2  = 2'b01,
		XSX_RETNOP = 2'b10
	} xsx_state_e;

	// data memory request
	typedef struct packed
	{
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} xsx_mem_req_s;

endpackage

/* xsx_ptr_file.sv */
// the three indirect pointers held as a small register memory
`timescale 1ns/10ps
module xsx_ptr_file
#(
	parameter int unsigned ADDR_W = 12
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              wr_i,
	input  wire logic [1:0]        wsel_i,
	input  wire logic [ADDR_W-1:0] wdata_i,
	output logic [ADDR_W-1:0]      ptr0_o,
	output logic [ADDR_W-1:0]      ptr1_o,
	output logic [ADDR_W-1:0]      ptr2_o
);

	logic [ADDR_W-1:0] mem_q [3];
	logic [ADDR_W-1:0] mem_d [3];

	always_comb
	begin
		mem_d = mem_q;
		if (wr_i && wsel_i != 2'h3)
			mem_d[wsel_i] = wdata_i;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			mem_q[2] <= '0;
		end
		else
			mem_q <= mem_d;
	end

	assign ptr0_o = mem_q[0];
	assign ptr1_o = mem_q[1];
	assign ptr2_o = mem_q[2];

endmodule // xsx_ptr_file

/* xsx_exec_test.sv */
// self-checking testbench for the extended stack instruction block
`timescale 1ns/10ps
module xsx_exec_test;

	logic        CLK_I;
	logic        RST_I;
	logic        EXT_ENABLE_I;
	logic        INSTR_VALID_I;
	logic [15:0] INSTR_I;
	logic [3:0]  BANK_SELECT_I;
	logic [7:0]  MEM_RDATA_I;
	logic [20:0] RETURN_STACK_TOP_I;
	logic        MEM_RD_O;
	logic        MEM_WR_O;
	logic [11:0] MEM_ADDR_O;
	logic [7:0]  MEM_WDATA_O;
	logic [11:0] OPERAND_ADDR_O;
	logic        OPERAND_TO_FILE_O;
	logic        PC_LOAD_O;
	logic [20:0] PC_VALUE_O;
	logic        BUSY_O;
	logic        EXT_ACTIVE_O;
	logic [11:0] STACK_FRAME_POINTER_O;
	int          bad_count;
	int          samples_checked;

	xsx_exec DUT
	(
		.CLK_I                 (CLK_I),
		.RST_I                 (RST_I),
		.EXT_ENABLE_I          (EXT_ENABLE_I),
		.INSTR_VALID_I         (INSTR_VALID_I),
		.INSTR_I               (INSTR_I),
		.BANK_SELECT_I         (BANK_SELECT_I),
		.MEM_RDATA_I           (MEM_RDATA_I),
		.RETURN_STACK_TOP_I    (RETURN_STACK_TOP_I),
		.MEM_RD_O              (MEM_RD_O),
		.MEM_WR_O              (MEM_WR_O),
		.MEM_ADDR_O            (MEM_ADDR_O),
		.MEM_WDATA_O           (MEM_WDATA_O),
		.OPERAND_ADDR_O        (OPERAND_ADDR_O),
		.OPERAND_TO_FILE_O     (OPERAND_TO_FILE_O),
		.PC_LOAD_O             (PC_LOAD_O),
		.PC_VALUE_O            (PC_VALUE_O),
		.BUSY_O                (BUSY_O),
		.EXT_ACTIVE_O          (EXT_ACTIVE_O),
		.STACK_FRAME_POINTER_O (STACK_FRAME_POINTER_O)
	);

	////////////////////////////////////////////////////////////////////////
	always #5 CLK_I = ~CLK_I;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one word taken at the second edge, outputs looked at just after it
	task automatic send(input logic [15:0] w);
		@(posedge CLK_I);
		INSTR_VALID_I <= 1'b1;
		INSTR_I       <= w;
		@(posedge CLK_I);
		INSTR_VALID_I <= 1'b0;
		#1;
	endtask

	// both move words back to back, source data given with the second word
	task automatic move(input logic [15:0] w1, input logic [15:0] w2, input logic [7:0] rd,
		input logic [11:0] src, input logic [11:0] dst, input logic wr, input logic [7:0] wd);
		@(posedge CLK_I);
		INSTR_VALID_I <= 1'b1;
		INSTR_I       <= w1;
		@(posedge CLK_I);
		INSTR_I       <= w2;
		MEM_RDATA_I   <= rd;
		#1;
		chk("move_rd", 1, MEM_RD_O);
		chk("move_src", src, MEM_ADDR_O);
		chk("move_busy", 1, BUSY_O);
		@(posedge CLK_I);
		INSTR_VALID_I <= 1'b0;
		#1;
		chk("move_wr", wr, MEM_WR_O);
		if (wr)
		begin
			chk("move_dst", dst, MEM_ADDR_O);
			chk("move_data", wd, MEM_WDATA_O);
		end
	endtask

	task automatic operand(input logic [15:0] w, input logic [11:0] a, input logic d);
		send(w);
		chk("operand_addr", a, OPERAND_ADDR_O);
		chk("operand_dest", d, OPERAND_TO_FILE_O);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		#20000;
		bad_count++;
		summarize();
	end

	initial
	begin
		CLK_I = 1'b0;
		RST_I = 1'b1;
		EXT_ENABLE_I = 1'b0;
		INSTR_VALID_I = 1'b0;
		INSTR_I = 16'h0000;
		BANK_SELECT_I = 4'h5;
		MEM_RDATA_I = 8'h00;
		RETURN_STACK_TOP_I = 21'h012345;
		bad_count = 0;
		samples_checked = 0;
		repeat (16) @(posedge CLK_I);
		RST_I <= 1'b0;
		#1;
		chk("ext_reset", 0, EXT_ACTIVE_O);
		chk("ptr_reset", 12'h000, STACK_FRAME_POINTER_O);
		// extension off: push ignored, literal file addresses
		send(16'hFA08);
		chk("off_push_wr", 0, MEM_WR_O);
		operand(16'h2620, 12'h020, 1'b1);
		operand(16'h2480, 12'hF80, 1'b0);
		operand(16'h2512, 12'h512, 1'b0);
		@(posedge CLK_I);
		EXT_ENABLE_I <= 1'b1;
		@(posedge CLK_I);
		#1;
		chk("ext_active", 1, EXT_ACTIVE_O);
		operand(16'h2620, 12'h020, 1'b1);
		// ignored bits of the second word all set
		move(16'hEB85, 16'hFF86, 8'h33, 12'h005, 12'h006, 1'b1, 8'h33);
		send(16'hFA08);
		chk("push_wr", 1, MEM_WR_O);
		chk("push_addr", 12'h000, MEM_ADDR_O);
		chk("push_data", 8'h08, MEM_WDATA_O);
		chk("push_ptr", 12'hFFF, STACK_FRAME_POINTER_O);
		send(16'hE9A3);
		chk("sub_ptr2", 12'hFDC, STACK_FRAME_POINTER_O);
		send(16'hE963);
		chk("sub_ptr1_keep", 12'hFDC, STACK_FRAME_POINTER_O);
		chk("sub_ptr1_pc", 0, PC_LOAD_O);
		operand(16'h2605, 12'hFE1, 1'b1);
		operand(16'h2460, 12'hF60, 1'b0);
		move(16'hEB83, 16'hF030, 8'hAA, 12'hFDF, 12'h00C, 1'b1, 8'h00);
		move(16'hEB90, 16'hF00B, 8'h55, 12'hFEC, 12'hFE7, 1'b0, 8'h00);
		// second word late: source byte kept from the cycle after the read
		@(posedge CLK_I);
		INSTR_VALID_I <= 1'b1;
		INSTR_I       <= 16'hEB81;
		@(posedge CLK_I);
		INSTR_I       <= 16'h0000;
		MEM_RDATA_I   <= 8'h5A;
		#1;
		chk("late_src", 12'hFDD, MEM_ADDR_O);
		@(posedge CLK_I);
		INSTR_I       <= 16'hF040;
		MEM_RDATA_I   <= 8'hC3;
		#1;
		chk("late_wait_wr", 0, MEM_WR_O);
		chk("late_wait_busy", 1, BUSY_O);
		@(posedge CLK_I);
		INSTR_VALID_I <= 1'b0;
		#1;
		chk("late_wr", 1, MEM_WR_O);
		chk("late_dst", 12'h01C, MEM_ADDR_O);
		chk("late_data", 8'h5A, MEM_WDATA_O);
		send(16'hE9C5);
		chk("ret_load", 1, PC_LOAD_O);
		chk("ret_value", 21'h012345, PC_VALUE_O);
		chk("ret_ptr", 12'hFD7, STACK_FRAME_POINTER_O);
		chk("ret_busy", 1, BUSY_O);
		@(posedge CLK_I);
		#1;
		chk("ret_nop_busy", 0, BUSY_O);
		chk("ret_nop_load", 0, PC_LOAD_O);
		@(posedge CLK_I);
		EXT_ENABLE_I <= 1'b0;
		@(posedge CLK_I);
		#1;
		chk("ext_off", 0, EXT_ACTIVE_O);
		send(16'hFA01);
		chk("off_push_ptr", 12'hFD7, STACK_FRAME_POINTER_O);
		chk("off_push_wr2", 0, MEM_WR_O);
		operand(16'h2605, 12'h005, 1'b1);
		summarize();
	end

endmodule // xsx_exec_test
